/* File: bench/ctr_host_model.sv */
// Host microcontroller model on the proximity/control pin and the touch pin.
// Assumes no pull on the pin: the host drives it only while the block releases it.
`timescale 1ns/1ps
`default_nettype none

module ctr_host_model (
  input  wire logic pclk,        // Clock
  input  wire logic prox_pin_o,  // Block pin drive
  input  wire logic prox_pin_oe, // Block pin enable
  input  wire logic touch_pin,   // Touch output
  input  wire logic halt_req,    // Host asks for a halt
  output logic      pin_level,   // Resolved pin level
  output int        touch_seen   // Touch rising edges seen
);
  logic touch_q;

  initial begin
    touch_q    = 1'b0;
    touch_seen = 0;
  end

  assign pin_level = prox_pin_oe ? prox_pin_o : halt_req;

  always @(posedge pclk) begin
    touch_q <= touch_pin;
    if (touch_pin === 1'b1 && touch_q === 1'b0) begin
      touch_seen <= touch_seen + 1;
    end
  end
endmodule : ctr_host_model

`default_nettype wire

/* File: bench/ctr_top_test.sv */
// Self-checking bench of the tuning block: APB master, sample source, host.
// Assumes the front end count grows as 100 per multiplier step plus 4 per comp step.
`timescale 1ns/1ps
`default_nettype none

module ctr_top_test;
  import ctr_pkg::*;

  logic                 pclk, presetn, psel, penable, pwrite, halt_req, pin_level;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 pready, pslverr, tune_busy, prox_pin_o, prox_pin_oe, touch_pin;
  logic                 charge_halt, err;
  ctr_sample_t          smp;
  ctr_tune_t            tune;
  int                   bad_count, checks_done, cycles, touch_seen;
  logic [15:0]          cur;
  typedef struct { logic [2:0] code; logic [7:0] sens; } ctr_row_t;
  ctr_row_t rows [8] = '{'{3'h0, 8'h06}, '{3'h1, 8'h18}, '{3'h2, 8'h10}, '{3'h3, 8'h0c},
                         '{3'h4, 8'h08}, '{3'h5, 8'h04}, '{3'h6, 8'h04}, '{3'h7, 8'h02}};

  ctr_top ctr_top_inst (.pclk(pclk), .presetn(presetn), .cen(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .smp(smp), .tune(tune), .tune_busy(tune_busy),
    .ctrl_pin_i(pin_level), .prox_pin_o(prox_pin_o), .prox_pin_oe(prox_pin_oe),
    .touch_pin(touch_pin), .charge_halt(charge_halt));

  ctr_host_model ctr_host_model_inst (.pclk(pclk), .prox_pin_o(prox_pin_o),
    .prox_pin_oe(prox_pin_oe), .touch_pin(touch_pin), .halt_req(halt_req),
    .pin_level(pin_level), .touch_seen(touch_seen));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // Setup, access, sample pready at each rising edge, release after the one it is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    check("apb ready", pready, 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic samp(input logic [15:0] c);
    @(posedge pclk);
    smp <= '{valid: 1'b1, count: c};
    @(posedge pclk);
    smp.valid <= 1'b0;
    @(negedge pclk);
  endtask : samp

  // Front end stand-in: sample count follows the tuning setting
  task automatic tune_run;
    int n;
    n = 0;
    while (tune_busy === 1'b1 && n < 600) begin
      check("quiet while busy", {prox_pin_o, touch_pin}, 2'b00);
      samp(16'(100 * tune.mult + 4 * tune.comp));
      n++;
    end
    cur = 16'(100 * tune.mult + 4 * tune.comp);
    check("tuning ended", tune_busy, 1'b0);
    check("coarse step", tune.mult, 4'h2);
    check("count on target", (cur >= 16'd1192 && cur <= 16'd1208), 1'b1);
    repeat (3) samp(cur);
  endtask : tune_run

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; smp = '0; halt_req = 1'b0; bad_count = 0; checks_done = 0; cycles = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("reset pins", {tune_busy, prox_pin_oe, prox_pin_o, touch_pin, tune}, 16'hc000);
    apb(1'b0, 8'h04, 32'h0);
    check("thr reset", rd, 32'h0028_0008);
    foreach (rows[i]) begin
      apb(1'b1, 8'h00, {21'h0, rows[i].code, 8'h00});
      apb(1'b0, 8'h08, 32'h0);
      check("sensitivity", rd[23:16], rows[i].sens);
    end
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped error", err, 1'b1);
    tune_run();
    apb(1'b0, 8'h0c, 32'h0);
    check("average follows", rd[15:0], cur);
    repeat (3) samp(cur - 16'd10);
    check("prox pins", {prox_pin_o, touch_pin, charge_halt}, 3'b100);
    apb(1'b0, 8'h0c, 32'h0);
    // Detecting sample still steps the average once
    check("average halted", rd[15:0], cur - 16'd1);
    samp(cur - 16'd50);
    apb(1'b0, 8'h08, 32'h0);
    check("pending", {rd[3], rd[2]}, 2'b11);
    apb(1'b0, 8'h0c, 32'h0);
    check("start release", rd[31:16], 16'd30);
    repeat (70) samp(cur - 16'd50);
    apb(1'b0, 8'h0c, 32'h0);
    // Tracks 21 samples, releases below 30, then proximity halts it
    check("recalibrated", rd[15:0], cur - 16'd22);
    check("touch released", touch_pin, 1'b0);
    cur = cur - 16'd22;
    // entry within the near window, both release settings
    apb(1'b1, 8'h04, {16'd12, 16'd4});
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, 8'h00, {25'h0, r[0], 6'h0});
      samp(cur - 16'd12);
      check("touch on", touch_pin, 1'b1);
      apb(1'b0, 8'h0c, 32'h0);
      check("near release", rd[31:16], r ? 16'd11 : 16'd9);
      repeat (20) samp(cur);
    end
    check("touches seen", touch_seen, 3);
    // pin as input gives halt charge
    apb(1'b1, 8'h00, 32'h0000_0080);
    halt_req <= 1'b1;
    repeat (3) @(negedge pclk);
    check("pin input", {prox_pin_oe, charge_halt}, 2'b01);
    halt_req <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    // small shift keeps tuning, large shift retunes
    repeat (4) samp(cur + 16'd100);
    check("no retune", tune_busy, 1'b0);
    samp(cur + 16'd250);
    repeat (4) @(negedge pclk);
    check("retune", {tune_busy, tune}, 13'h1000);
    tune_run();
    apb(1'b1, 8'h08, 32'hffff_ffff);
    apb(1'b0, 8'h08, 32'h0);
    check("status read only", rd[3:0], 4'h0);
    finish_test();
  end
endmodule : ctr_top_test

`default_nettype wire

/* File: logic/ctr_defines.svh */
// Offsets, field positions, reset values and counts of the tuning block.
// Assumes a 32-bit APB with byte addresses and 16-bit sample counts.
`ifndef CTR_DEFINES_SVH
`define CTR_DEFINES_SVH

// Register byte offsets
`define CTR_OFF_CFG        8'h00
`define CTR_OFF_THR        8'h04
`define CTR_OFF_STAT       8'h08
`define CTR_OFF_AVG        8'h0c

// Configuration word: bank 0 in [7:0], bank 1 in [15:8]
`define CTR_CFG_PIN_IN     7
`define CTR_CFG_REL_SEL    6
`define CTR_CFG_BASE_LO    8
`define CTR_CFG_BASE_HI    10

// Status word fields
`define CTR_ST_BUSY        0
`define CTR_ST_PROX        1
`define CTR_ST_TOUCH       2
`define CTR_ST_PEND        3

// Reset values
`define CTR_PROX_THR_RST   16'h0008
`define CTR_TOUCH_THR_RST  16'h0028

// Tuning target 1200, tolerance, retune shift, near window 16
`define CTR_TARGET         16'h04b0
`define CTR_TOL            16'h0008
`define CTR_RETUNE_SHIFT   16'h00c8
`define CTR_NEAR           16'h0010

`endif

/* File: logic/ctr_pkg.sv */
// Types and shared arithmetic of the capacitive tuning block.
// Assumes ctr_defines.svh is on the include path.
`include "ctr_defines.svh"

package ctr_pkg;

  typedef enum logic [1:0] {
    CTR_IDLE = 2'b00,
    CTR_MULT = 2'b01,
    CTR_COMP = 2'b11
  } ctr_tune_st_t;

  typedef struct packed {
    logic       pin_input;
    logic       rel_sel;
    logic [2:0] base_sel;
  } ctr_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] count;
  } ctr_sample_t;

  typedef struct packed {
    logic [3:0] mult;
    logic [7:0] comp;
  } ctr_tune_t;

  typedef struct packed {
    ctr_tune_st_t st;
    ctr_tune_t    tune;
    logic         busy;
    logic         done;
  } ctr_tuner_t;

  typedef struct packed {
    logic [15:0] entry_lta;
    logic [15:0] delta;
    logic        pending;
    logic [15:0] rthr;
  } ctr_rel_t;

  typedef struct packed {
    ctr_cfg_t    cfg;
    logic [15:0] prox_thr;
    logic [15:0] touch_thr;
    logic [15:0] long_term_average;
    logic        prox;
    logic        touch;
    logic        touch_enter;
    logic        retune;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        prox_o;
    logic        prox_oe;
    logic        touch_o;
    logic        charge_halt;
  } ctr_main_t;

  function automatic logic [15:0] ctr_absdiff(input logic [15:0] a, input logic [15:0] b);
    ctr_absdiff = (a > b) ? (a - b) : (b - a);
  endfunction : ctr_absdiff

  function automatic logic ctr_near(input logic [15:0] a, input logic [15:0] b);
    ctr_near = (ctr_absdiff(a, b) <= `CTR_NEAR);
  endfunction : ctr_near

  function automatic logic [15:0] ctr_base_of(input logic [2:0] code);
    case (code)
      3'h0:    ctr_base_of = 16'h00c8;
      3'h1:    ctr_base_of = 16'h0032;
      3'h2:    ctr_base_of = 16'h004b;
      3'h3:    ctr_base_of = 16'h0064;
      3'h4:    ctr_base_of = 16'h0096;
      3'h5:    ctr_base_of = 16'h00fa;
      3'h6:    ctr_base_of = 16'h012c;
      default: ctr_base_of = 16'h01f4;
    endcase
  endfunction : ctr_base_of

  function automatic logic [7:0] ctr_sens_of(input logic [2:0] code);
    logic [15:0] q;
    q = `CTR_TARGET / ctr_base_of(code);
    ctr_sens_of = q[7:0];
  endfunction : ctr_sens_of

endpackage : ctr_pkg

/* File: logic/ctr_release.sv */
// Entry delta capture and touch release threshold.
// Assumes touch_enter pulses in the cycle after the sample that enters touch.
`timescale 1ns/1ps
`default_nettype none

module ctr_release
  import ctr_pkg::*;
(
  input  wire logic        pclk,        // Clock
  input  wire logic        presetn,     // Async reset, low
  input  wire logic        cen,         // Clock enable
  input  wire logic        smp_valid,   // Sample strobe
  input  wire logic [15:0] count,       // Current count
  input  wire logic [15:0] long_term_average,         // Current long-term average
  input  wire logic        touch_on,    // Touch state held
  input  wire logic        touch_enter, // Touch entered pulse
  input  wire logic        rel_sel,     // Release threshold select
  input  wire logic [15:0] touch_thr,   // Touch threshold
  output logic             pending,     // Waiting for average to settle
  output logic [15:0]      release_thr  // Release threshold
);
  import ctr_pkg::*;

  ctr_rel_t s;
  ctr_rel_t next_s;

  always_comb begin
    next_s = s;
    if (touch_enter) begin
      next_s.entry_lta = long_term_average;
      next_s.delta     = touch_thr;
      next_s.pending   = !ctr_near(long_term_average, count);
    end else if (smp_valid && touch_on && s.pending && ctr_near(long_term_average, count)) begin
      next_s.delta   = (s.entry_lta > long_term_average) ? (s.entry_lta - long_term_average) : touch_thr;
      next_s.pending = 1'b0;
    end
    next_s.rthr = rel_sel ? (next_s.delta - (next_s.delta >> 3))
                          : (next_s.delta - (next_s.delta >> 2));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (cen) begin
      s <= next_s;
    end
  end

  assign pending     = s.pending;
  assign release_thr = s.rthr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_REL_RATIO: assert property (s.rthr == (rel_sel ? s.delta - (s.delta >> 3) : s.delta - (s.delta >> 2)) || !$stable(rel_sel))
    else $error("release threshold not the selected fraction");
  AST_ENTRY_NEAR: assert property ((cen && touch_enter && ctr_near(long_term_average, count)) |=> !s.pending && s.delta == $past(touch_thr))
    else $error("settled entry did not take touch threshold");
  AST_ENTRY_CALC: assert property ((cen && !touch_enter && smp_valid && touch_on && s.pending && ctr_near(long_term_average, count) && s.entry_lta > long_term_average) |=> s.delta == $past(s.entry_lta) - $past(long_term_average))
    else $error("entry delta not entry minus current average");

endmodule : ctr_release

`default_nettype wire

/* File: logic/ctr_top.sv */
// Capacitive tuning, hysteresis and pin control with an APB register file.
// Assumes samples arrive as a one-cycle strobe with a count, synchronous to pclk.
//
// Functional notes
// - Tune counts toward fixed target 1200.
// - Sensitivity is target divided by base.
// - Bank 1 bits 2:0 select base value.
// - While tuning, flag busy, detect nothing.
// - Retune only after large count shift.
// - Run tuning at every start-up.
// - Release at 75 or 87.5 percent.
// - Entry delta is entry minus current average.
// - Settled at entry uses touch threshold.
// - Bank 0 bit 7 sets pin direction.
// - Output pin active on proximity.
// - Output mode disables halt inputs.
// - Proximity halts average, not touch pin.
// - Average recalibrates during touch.
// - Multiplier coarse, compensation fine.
`timescale 1ns/1ps
`default_nettype none

module ctr_top
  import ctr_pkg::*;
(
  input  wire logic               pclk,        // APB clock, 125 MHz
  input  wire logic               presetn,     // Async reset, low
  input  wire logic               cen,         // Clock enable, freezes state
  input  wire logic               psel,        // APB select
  input  wire logic               penable,     // APB enable
  input  wire logic               pwrite,      // APB write
  input  wire logic [7:0]         paddr,       // APB byte address
  input  wire logic [31:0]        pwdata,      // APB write data
  output logic [31:0]             prdata,      // APB read data
  output logic                    pready,      // APB ready
  output logic                    pslverr,     // APB error
  input  wire ctr_pkg::ctr_sample_t smp,       // Sample strobe and count
  output ctr_pkg::ctr_tune_t      tune,        // Front-end tuning setting
  output logic                    tune_busy,   // Tuning in progress
  input  wire logic               ctrl_pin_i,  // Proximity/control pin level
  output logic                    prox_pin_o,  // Proximity pin drive
  output logic                    prox_pin_oe, // Proximity pin enable
  output logic                    touch_pin,   // Touch output
  output logic                    charge_halt  // Halt charge request
);
  import ctr_pkg::*;

  localparam ctr_main_t RST = '{
    prox_thr:  `CTR_PROX_THR_RST,
    touch_thr: `CTR_TOUCH_THR_RST,
    prox_oe:   1'b1,
    default:   '0
  };

  ctr_main_t   s;
  ctr_main_t   next_s;
  logic        t_busy;
  logic        t_done;
  logic        r_pend;
  logic [15:0] r_thr;
  logic [15:0] base_val;
  logic [15:0] delta;
  logic        halt_in;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  assign base_val = ctr_base_of(s.cfg.base_sel);

  ctr_tuner u_tuner (
    .pclk     (pclk),
    .presetn  (presetn),
    .cen      (cen),
    .smp      (smp),
    .base_val (base_val),
    .start    (s.retune),
    .busy     (t_busy),
    .done     (t_done),
    .tune     (tune)
  );

  ctr_release u_release (
    .pclk        (pclk),
    .presetn     (presetn),
    .cen         (cen),
    .smp_valid   (smp.valid),
    .count       (smp.count),
    .long_term_average         (s.long_term_average),
    .touch_on    (s.touch),
    .touch_enter (s.touch_enter),
    .rel_sel     (s.cfg.rel_sel),
    .touch_thr   (s.touch_thr),
    .pending     (r_pend),
    .release_thr (r_thr)
  );

  assign tune_busy = t_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Detection, average and registers

  assign delta   = (s.long_term_average > smp.count) ? (s.long_term_average - smp.count) : 16'h0000;
  // halt input only when pin is an input
  assign halt_in = s.cfg.pin_input && ctrl_pin_i;

  always_comb begin
    next_s             = s;
    next_s.touch_enter = 1'b0;
    next_s.retune      = 1'b0;
    next_s.pready      = 1'b0;
    next_s.pslverr     = 1'b0;

    if (t_busy) begin
      next_s.prox  = 1'b0;
      next_s.touch = 1'b0;
      if (smp.valid) begin
        next_s.long_term_average = smp.count;
      end
    end else if (smp.valid) begin
      next_s.prox = (delta >= s.prox_thr);
      if (!s.touch && delta >= s.touch_thr) begin
        next_s.touch       = 1'b1;
        next_s.touch_enter = 1'b1;
      end else if (s.touch && delta < r_thr) begin
        next_s.touch = 1'b0;
      end
      // average halts on proximity, tracks in touch
      if (!halt_in && (!s.prox || s.touch)) begin
        if (s.long_term_average < smp.count) begin
          next_s.long_term_average = s.long_term_average + 16'h0001;
        end else if (s.long_term_average > smp.count) begin
          next_s.long_term_average = s.long_term_average - 16'h0001;
        end
      end
      if (!s.prox && !s.touch && ctr_absdiff(smp.count, `CTR_TARGET) > `CTR_RETUNE_SHIFT) begin
        next_s.retune = 1'b1;
      end
    end

    // APB slave: answer in the second access cycle
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        `CTR_OFF_CFG: begin
          if (pwrite) begin
            next_s.cfg.pin_input = pwdata[`CTR_CFG_PIN_IN];
            next_s.cfg.rel_sel   = pwdata[`CTR_CFG_REL_SEL];
            next_s.cfg.base_sel  = pwdata[`CTR_CFG_BASE_HI:`CTR_CFG_BASE_LO];
          end else begin
            next_s.prdata[`CTR_CFG_PIN_IN]                   = s.cfg.pin_input;
            next_s.prdata[`CTR_CFG_REL_SEL]                  = s.cfg.rel_sel;
            next_s.prdata[`CTR_CFG_BASE_HI:`CTR_CFG_BASE_LO] = s.cfg.base_sel;
          end
        end
        `CTR_OFF_THR: begin
          if (pwrite) begin
            next_s.prox_thr  = pwdata[15:0];
            next_s.touch_thr = pwdata[31:16];
          end else begin
            next_s.prdata = {s.touch_thr, s.prox_thr};
          end
        end
        `CTR_OFF_STAT: begin
          if (!pwrite) begin
            next_s.prdata[`CTR_ST_BUSY]  = t_busy;
            next_s.prdata[`CTR_ST_PROX]  = s.prox;
            next_s.prdata[`CTR_ST_TOUCH] = s.touch;
            next_s.prdata[`CTR_ST_PEND]  = r_pend;
            next_s.prdata[7:4]           = tune.mult;
            next_s.prdata[15:8]          = tune.comp;
            next_s.prdata[23:16]         = ctr_sens_of(s.cfg.base_sel);
          end
        end
        `CTR_OFF_AVG: begin
          if (!pwrite) begin
            next_s.prdata = {r_thr, s.long_term_average};
          end
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // pin direction and drive, after any config write
    next_s.prox_oe     = !next_s.cfg.pin_input;
    next_s.prox_o      = next_s.prox && !next_s.cfg.pin_input;
    next_s.touch_o     = next_s.touch;
    next_s.charge_halt = next_s.cfg.pin_input && ctrl_pin_i;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RST;
    end else if (cen) begin
      s <= next_s;
    end
  end

  assign prdata      = s.prdata;
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;
  assign prox_pin_o  = s.prox_o;
  assign prox_pin_oe = s.prox_oe;
  assign touch_pin   = s.touch_o;
  assign charge_halt = s.charge_halt;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BUSY_BLOCKS: assert property ((cen && t_busy) |=> !s.prox && !s.touch)
    else $error("event seen while tuning");
  AST_RETUNE_START: assert property ((cen && s.retune && !t_busy) |=> t_busy)
    else $error("retune request did not start tuning");
  AST_PIN_DIR: assert property (cen |=> prox_pin_oe != $past(next_s.cfg.pin_input))
    else $error("pin direction does not follow select bit");
  AST_PIN_PROX: assert property (prox_pin_o == (s.prox && prox_pin_oe))
    else $error("proximity pin not driven by proximity");
  AST_HALT_OUT: assert property (prox_pin_oe |-> !charge_halt)
    else $error("halt function active in output mode");
  AST_LTA_HOLD: assert property ((cen && smp.valid && !t_busy && s.prox && !s.touch) |=> $stable(s.long_term_average))
    else $error("average moved during proximity");
  AST_PROX_NO_TOUCH: assert property ((cen && smp.valid && !t_busy && !s.touch && delta < s.touch_thr) |=> !touch_pin)
    else $error("touch pin set below touch threshold");
  AST_LTA_TRACK: assert property ((cen && smp.valid && !t_busy && s.touch && !halt_in && s.long_term_average != smp.count) |=> !$stable(s.long_term_average))
    else $error("average frozen during touch");
  AST_APB_ANSWER: assert property ((cen && psel && penable && !pready) |=> pready ##1 !pready || !cen)
    else $error("APB access not answered in one cycle");

  COV_TOUCH_ENTER: cover property (s.touch_enter);
  COV_PROX_PIN: cover property ($rose(prox_pin_o));
  COV_RETUNE: cover property (s.retune ##1 t_busy);
  COV_APB_ERR: cover property (pslverr);

endmodule : ctr_top

`default_nettype wire

/* File: logic/ctr_tuner.sv */
// Automatic tuning sequencer: multiplier then compensation, per sample.
// Assumes the count rises with both multiplier and compensation.
`timescale 1ns/1ps
`default_nettype none

module ctr_tuner
  import ctr_pkg::*;
(
  input  wire logic               pclk,     // Clock
  input  wire logic               presetn,  // Async reset, low
  input  wire logic               cen,      // Clock enable
  input  wire ctr_pkg::ctr_sample_t smp,    // Sample strobe and count
  input  wire logic [15:0]        base_val, // Selected base value
  input  wire logic               start,    // Retune request pulse
  output logic                    busy,     // Tuning in progress
  output logic                    done,     // Tuning finished pulse
  output ctr_pkg::ctr_tune_t      tune      // Multiplier and compensation
);
  import ctr_pkg::*;

  localparam ctr_tuner_t RST = '{st: CTR_MULT, tune: '0, busy: 1'b1, done: 1'b0};

  ctr_tuner_t s;
  ctr_tuner_t next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (start && s.st == CTR_IDLE) begin
      next_s.st   = CTR_MULT;
      next_s.busy = 1'b1;
      next_s.tune = '0;
    end else if (smp.valid) begin
      case (s.st)
        CTR_MULT: begin
          if (smp.count < base_val && s.tune.mult != 4'hf) begin
            next_s.tune.mult = s.tune.mult + 4'h1;
          end else begin
            next_s.st = CTR_COMP;
          end
        end
        CTR_COMP: begin
          if (smp.count < `CTR_TARGET - `CTR_TOL && s.tune.comp != 8'hff) begin
            next_s.tune.comp = s.tune.comp + 8'h01;
          end else if (smp.count > `CTR_TARGET + `CTR_TOL && s.tune.comp != 8'h00) begin
            next_s.tune.comp = s.tune.comp - 8'h01;
          end else begin
            next_s.st   = CTR_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end
        end
        default: next_s.st = CTR_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= RST;
    end else if (cen) begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
  assign tune = s.tune;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TUNE_END: assert property ($fell(s.busy) |-> $past(s.st) == CTR_COMP)
    else $error("tuning ended outside compensation step");
  AST_MULT_FIRST: assert property ((cen && start && s.st == CTR_IDLE) |=> s.st == CTR_MULT && s.tune == '0)
    else $error("retune did not restart at multiplier step");
  COV_TUNE_DONE: cover property (s.done);

endmodule : ctr_tuner

`default_nettype wire
